// *** hdl/wdt_defs.svh ***
// Watchdog timer register map, field positions, reset values and counts
// Operation
// - The watchdog is a 14-bit down-counter stepped by count-source ticks, with count source protection on or off.
// - With protection off the ticks come from the CPU clock, with it on from the low-speed oscillator.
// - The refresh window field sets the refresh period as 25%, 50%, 75% or 100% of the full count period.
// - An erased option byte reads as all ones, selecting every default.
// - The counter can start in one of two selectable ways.
// - The underflow period field loads 03FFh, 0FFFh, 1FFFh or 3FFFh into the counter.
// - Counting starts either by itself after reset or on a write to the start register.
// - Writing 00h then FFh to the refresh register inside the window reloads the counter, as do reset and underflow.
// - Without protection the counter halts in low-power modes; with protection it keeps counting in low-power modes.
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// Register offsets
`define WDT_OPT_OFFSET 16'hffdb
`define WDT_CTRL_OFFSET 16'h0010
`define WDT_REFRESH_OFFSET 16'h0011
`define WDT_START_OFFSET 16'h0012
`define WDT_STATUS_OFFSET 16'h0013
`define WDT_MASK_OFFSET 16'h0014
`define WDT_CNT_LO_OFFSET 16'h0015
`define WDT_CNT_HI_OFFSET 16'h0016

// Option byte fields
`define WDT_UFS_LSB 0
`define WDT_RCS_LSB 2
`define WDT_OPT_RESET 8'hff

// Control fields
`define WDT_CTRL_PROTECT 0
`define WDT_CTRL_EVT_RESET 1
`define WDT_CTRL_AUTO 2

// Status and mask fields
`define WDT_ST_UNDERFLOW 0
`define WDT_ST_REFRESH 1
`define WDT_ST_WIN_ERR 2

// Counter load values
`define WDT_INIT_03FF 14'h03ff
`define WDT_INIT_0FFF 14'h0fff
`define WDT_INIT_1FFF 14'h1fff
`define WDT_INIT_3FFF 14'h3fff

// Refresh sequence bytes
`define WDT_REFRESH_ARM 8'h00
`define WDT_REFRESH_FIRE 8'hff

// Counts
`define WDT_CPU_DIV 16
`define WDT_BOOT_DONE 2'h3

`endif

// *** hdl/wdt_pkg.sv ***
// Watchdog timer shared types
package wdt_pkg;
  typedef logic [13:0] wdt_count_t;
  typedef enum logic [1:0] {win_quarter, win_half, win_three_quarter, win_full} win_sel_e;
endpackage

// *** hdl/wdt_tick_if.sv ***
// Count-source tick carrier between counter and tick generator
`timescale 1ns/1ps
`default_nettype none
interface wdt_tick_if;
  logic tick;
  logic protect;
  logic halt;
  modport gen (output tick, input protect, input halt);
  modport use_tick (input tick, output protect, output halt);
endinterface
`default_nettype wire

// *** hdl/wdt_tick_gen.sv ***
// Count-source tick generator: CPU prescaler or synchronised oscillator
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.svh"
module wdt_tick_gen import wdt_pkg::*; #(
  parameter int CPU_DIV = `WDT_CPU_DIV
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_en,
  // Low-speed oscillator pin
  input wire logic lsosc_pin,
  // Tick carrier
  wdt_tick_if.gen tif
);
  logic lsosc_s1, lsosc_s2, lsosc_s3;
  logic [7:0] pre;
  wire pre_hit = (pre == 8'(CPU_DIV - 1));
  wire osc_rise = lsosc_s2 && !lsosc_s3;

  // Oscillator synchroniser; only s2 and s3 feed the edge detect
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lsosc_s1 <= 1'b0;
      lsosc_s2 <= 1'b0;
      lsosc_s3 <= 1'b0;
    end else if (clock_en) begin
      lsosc_s1 <= lsosc_pin;
      lsosc_s2 <= lsosc_s1;
      lsosc_s3 <= lsosc_s2;
    end
  end

  // CPU clock prescaler
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) pre <= 8'h00;
    else if (clock_en) pre <= pre_hit ? 8'h00 : pre + 8'h01;
  end

  // Source select and low-power gating; protection ignores halt
  assign tif.tick = tif.protect ? osc_rise : (pre_hit && !tif.halt);

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  a_halt_gate: assert property (tif.halt && !tif.protect |-> !tif.tick)
    else $error("tick while halted without protection");
  a_osc_source: assert property (tif.protect && tif.tick |-> lsosc_s2 && !lsosc_s3)
    else $error("protected tick not from oscillator edge");
  a_cpu_period: assert property (!tif.protect && tif.tick && clock_en |=> !tif.tick)
    else $error("cpu ticks back to back");
endmodule
`default_nettype wire

// *** hdl/watchdog_timer.sv ***
// Watchdog timer: option byte, 14-bit counter, refresh window, events
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.svh"
module watchdog_timer import wdt_pkg::*; #(
  parameter int CPU_DIV = `WDT_CPU_DIV
) (
  // Clock, reset, freeze
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_en,
  // Register port
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  // Flash programming and power state
  input wire logic prog_en,
  input wire logic low_power,
  // Pins: oscillator and reset straps
  input wire logic lsosc_pin,
  input wire logic start_auto_strap,
  input wire logic protect_strap,
  // Events
  output logic irq,
  output logic wdt_reset_req
);
  wdt_tick_if tif ();

  logic [7:0] watchdog_option_byte;
  logic protect, evt_reset, auto_start;
  logic running, armed;
  wdt_count_t count, next_count;
  logic [2:0] status, mask;
  logic [1:0] boot;
  logic auto_s1, auto_s2, prot_s1, prot_s2;

  // Address decode
  wire wr_opt = wr_stb && addr == `WDT_OPT_OFFSET && prog_en;
  wire wr_ctrl = wr_stb && addr == `WDT_CTRL_OFFSET;
  wire wr_refresh = wr_stb && addr == `WDT_REFRESH_OFFSET;
  wire wr_start = wr_stb && addr == `WDT_START_OFFSET;
  wire wr_mask = wr_stb && addr == `WDT_MASK_OFFSET;
  wire rd_status = rd_stb && addr == `WDT_STATUS_OFFSET;

  // Option fields and counter load value
  wire [1:0] ufs = watchdog_option_byte[`WDT_UFS_LSB +: 2];
  win_sel_e rcs;
  assign rcs = win_sel_e'(watchdog_option_byte[`WDT_RCS_LSB +: 2]);
  wire wdt_count_t init_value = (ufs == 2'h0) ? `WDT_INIT_03FF :
                               (ufs == 2'h1) ? `WDT_INIT_0FFF :
                               (ufs == 2'h2) ? `WDT_INIT_1FFF : `WDT_INIT_3FFF;

  // Window limit: refresh taken only in the last part of the period
  wire wdt_count_t quarter = init_value >> 2;
  wire wdt_count_t half = init_value >> 1;
  wire wdt_count_t win_limit = (rcs == win_quarter) ? quarter :
                              (rcs == win_half) ? half :
                              (rcs == win_three_quarter) ? init_value - quarter : init_value;
  wire in_window = count <= win_limit;

  // Sequence and event decode
  wire fire = wr_refresh && wdata == `WDT_REFRESH_FIRE && armed && running;
  wire refresh_go = fire && in_window;
  wire refresh_bad = fire && !in_window;
  wire uf_go = running && tif.tick && count == 14'h0000;
  wire boot_now = boot == `WDT_BOOT_DONE - 2'h1;
  wire start_go = (wr_start && !running) || (boot_now && auto_s2);
  wire [2:0] events = {refresh_bad, refresh_go, uf_go};

  // Counter next value: reload beats decrement
  assign next_count = (start_go || refresh_go || uf_go) ? init_value :
                      (running && tif.tick) ? count - 14'h0001 : count;

  assign tif.protect = protect;
  assign tif.halt = low_power;

  wdt_tick_gen #(.CPU_DIV(CPU_DIV)) u_tick (
    .clock(clock),
    .resetn(resetn),
    .clock_en(clock_en),
    .lsosc_pin(lsosc_pin),
    .tif(tif)
  );

  // Option byte; erased state is all ones, written only when programming
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) watchdog_option_byte <= `WDT_OPT_RESET;
    else if (clock_en && wr_opt) watchdog_option_byte <= wdata;
  end

  // Strap synchronisers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      auto_s1 <= 1'b0;
      auto_s2 <= 1'b0;
      prot_s1 <= 1'b0;
      prot_s2 <= 1'b0;
    end else if (clock_en) begin
      auto_s1 <= start_auto_strap;
      auto_s2 <= auto_s1;
      prot_s1 <= protect_strap;
      prot_s2 <= prot_s1;
    end
  end

  // Boot counter waits out the synchroniser before straps are caught
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) boot <= 2'h0;
    else if (clock_en && boot != `WDT_BOOT_DONE) boot <= boot + 2'h1;
  end

  // Control: protection can be set but never cleared by software
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      protect <= 1'b0;
      evt_reset <= 1'b0;
      auto_start <= 1'b0;
    end else if (clock_en) begin
      if (boot_now) begin
        protect <= prot_s2;
        auto_start <= auto_s2;
      end else if (wr_ctrl) begin
        protect <= protect | wdata[`WDT_CTRL_PROTECT];
        evt_reset <= wdata[`WDT_CTRL_EVT_RESET];
      end
    end
  end

  // Run flag and refresh arming; any other refresh byte disarms
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      running <= 1'b0;
      armed <= 1'b0;
    end else if (clock_en) begin
      if (start_go) running <= 1'b1;
      if (wr_refresh) armed <= wdata == `WDT_REFRESH_ARM;
    end
  end

  // Counter
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) count <= `WDT_INIT_3FFF;
    else if (clock_en) count <= next_count;
  end

  // Sticky status: a new event wins over the read clear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) status <= 3'h0;
    else if (clock_en) status <= (rd_status ? 3'h0 : status) | events;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) mask <= 3'h0;
    else if (clock_en && wr_mask) mask <= wdata[2:0];
  end

  // Reset request; protection forces reset regardless of select
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) wdt_reset_req <= 1'b0;
    else if (clock_en) wdt_reset_req <= uf_go && (protect || evt_reset);
  end

  // Interrupt only when reset is not chosen for underflow; other causes still interrupt
  wire uf_to_reset = protect || evt_reset;
  wire [2:0] irq_src = status & mask & {2'h3, !uf_to_reset};
  assign irq = |irq_src;

  // Read mux; unmapped addresses read zero
  wire [7:0] rd_mux =
    (addr == `WDT_OPT_OFFSET) ? watchdog_option_byte :
    (addr == `WDT_CTRL_OFFSET) ? {5'h00, auto_start, evt_reset, protect} :
    (addr == `WDT_STATUS_OFFSET) ? {5'h00, status} :
    (addr == `WDT_MASK_OFFSET) ? {5'h00, mask} :
    (addr == `WDT_CNT_LO_OFFSET) ? count[7:0] :
    (addr == `WDT_CNT_HI_OFFSET) ? {2'h0, count[13:8]} : 8'h00;

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) rdata <= 8'h00;
    else if (clock_en) rdata <= rd_stb ? rd_mux : 8'h00;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  a_count_step: assert property (clock_en && running && tif.tick && count != 14'h0000 &&
    !refresh_go && !start_go |=> count == $past(count) - 14'h0001)
    else $error("counter did not decrement by one");
  a_underflow_load: assert property (clock_en && uf_go |=> count == $past(init_value))
    else $error("underflow did not reload");
  a_refresh_load: assert property (clock_en && refresh_go |=> count == $past(init_value))
    else $error("refresh did not reload");
  a_window_gate: assert property (refresh_go |-> count <= win_limit)
    else $error("refresh outside window");
  a_init_long: assert property (ufs == 2'h3 |-> init_value == 14'h3fff)
    else $error("longest period load wrong");
  a_start_write: assert property (clock_en && wr_start && !running |=> running)
    else $error("start write ignored");
  a_protect_reset: assert property (clock_en && uf_go && protect |=> wdt_reset_req)
    else $error("protected underflow gave no reset");
  a_irq_raise: assert property (clock_en && uf_go && mask[0] && !uf_to_reset &&
    !wr_ctrl && !wr_mask ##1 !rd_status |-> irq)
    else $error("unmasked underflow gave no interrupt");
  a_erased_default: assert property (boot == 2'h0 |-> watchdog_option_byte == 8'hff)
    else $error("option byte not erased after reset");
  a_halt_hold: assert property (clock_en && low_power && !protect && running && !refresh_go &&
    !start_go |=> count == $past(count))
    else $error("counter moved while halted");
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the watchdog timer over its register port
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.svh"
module tb_top;
  localparam int DIV = 2;
  logic clock, resetn, clock_en, wr_stb, rd_stb, prog_en, low_power, lsosc_pin;
  logic start_auto_strap, protect_strap;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, got, hi;
  logic irq, wdt_reset_req;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  logic [13:0] init_tab [4] = '{14'h03ff, 14'h0fff, 14'h1fff, 14'h3fff};

  watchdog_timer #(.CPU_DIV(DIV)) u_dut (
    .clock(clock), .resetn(resetn), .clock_en(clock_en),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .prog_en(prog_en), .low_power(low_power), .lsosc_pin(lsosc_pin),
    .start_auto_strap(start_auto_strap), .protect_strap(protect_strap),
    .irq(irq), .wdt_reset_req(wdt_reset_req));

  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Ceiling well above the longest wait chain
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: byte got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: flag got %b expected %b", $time, g, e);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask

  // Both refresh bytes back to back, so nothing disarms in between
  task automatic refresh();
    @(posedge clock);
    addr <= `WDT_REFRESH_OFFSET;
    wdata <= `WDT_REFRESH_ARM;
    wr_stb <= 1'b1;
    @(posedge clock);
    wdata <= `WDT_REFRESH_FIRE;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask

  task automatic chk_cnt(input logic [13:0] e);
    rd(`WDT_CNT_LO_OFFSET, got);
    rd(`WDT_CNT_HI_OFFSET, hi);
    chk8(got, e[7:0]);
    chk8(hi, {2'h0, e[13:8]});
  endtask

  // Bounded wait for irq (0) or the reset request pulse (1)
  task automatic wait_evt(input bit sel);
    for (int i = 0; i < 3000; i++) begin
      @(posedge clock);
      #1;
      if (sel ? wdt_reset_req : irq) break;
    end
  endtask

  // Reset for n cycles, then wait out the strap capture before any access
  task automatic do_reset(input int n);
    resetn <= 1'b0;
    repeat (n) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
  endtask

  initial begin
    {resetn, wr_stb, rd_stb, prog_en, low_power, lsosc_pin} = '0;
    {start_auto_strap, protect_strap, addr, wdata} = '0;
    clock_en = 1'b1;
    do_reset(20);
    rd(`WDT_OPT_OFFSET, got);
    chk8(got, `WDT_OPT_RESET);
    chk_cnt(14'h3fff);
    rd(`WDT_CTRL_OFFSET, got);
    chk8(got, 8'h00);
    // Option byte refuses writes outside programming
    wr(`WDT_OPT_OFFSET, 8'hf0);
    rd(`WDT_OPT_OFFSET, got);
    chk8(got, 8'hff);
    // Ticks halted so loaded values can be read exactly
    low_power <= 1'b1;
    prog_en <= 1'b1;
    wr(`WDT_OPT_OFFSET, 8'hfc);
    wr(`WDT_START_OFFSET, 8'h00);
    chk_cnt(14'h03ff);
    for (int c = 0; c < 4; c++) begin
      wr(`WDT_OPT_OFFSET, 8'hfc | 8'(c));
      refresh();
      chk_cnt(init_tab[c]);
    end
    // Reset mid-run: option byte erased again, counter stopped, status clear
    do_reset(2);
    rd(`WDT_OPT_OFFSET, got);
    chk8(got, `WDT_OPT_RESET);
    wr(`WDT_OPT_OFFSET, 8'hf0);
    rd(`WDT_OPT_OFFSET, got);
    chk8(got, 8'hf0);
    wr(`WDT_START_OFFSET, 8'h00);
    rd(`WDT_STATUS_OFFSET, got);
    chk8(got, 8'h00);
    refresh();
    rd(`WDT_STATUS_OFFSET, got);
    chk8(got, 8'h04);
    rd(`WDT_STATUS_OFFSET, got);
    chk8(got, 8'h00);
    // Let it run into the last quarter, then refresh inside the window
    low_power <= 1'b0;
    repeat (1600) @(posedge clock);
    refresh();
    rd(`WDT_STATUS_OFFSET, got);
    chk8(got, 8'h02);
    rd(`WDT_CNT_HI_OFFSET, hi);
    chk8(hi, 8'h03);
    // Underflow as interrupt, then as reset request
    wr(`WDT_MASK_OFFSET, 8'h01);
    wait_evt(1'b0);
    chk1(irq, 1'b1);
    rd(`WDT_STATUS_OFFSET, got);
    chk8(got, 8'h01);
    chk1(irq, 1'b0);
    wr(`WDT_CTRL_OFFSET, 8'h02);
    wait_evt(1'b1);
    chk1(wdt_reset_req, 1'b1);
    chk1(irq, 1'b0);
    // Protection: set-only, oscillator ticks, no halt in low power
    low_power <= 1'b1;
    wr(`WDT_CTRL_OFFSET, 8'h01);
    wr(`WDT_CTRL_OFFSET, 8'h00);
    rd(`WDT_CTRL_OFFSET, got);
    chk8(got, 8'h01);
    wr(`WDT_OPT_OFFSET, 8'hfc);
    refresh();
    repeat (10) @(posedge clock);
    chk_cnt(14'h03ff);
    repeat (5) begin
      repeat (4) @(posedge clock);
      lsosc_pin <= 1'b1;
      repeat (4) @(posedge clock);
      lsosc_pin <= 1'b0;
    end
    repeat (6) @(posedge clock);
    chk_cnt(14'h03fa);
    // Straps high over a reset: protected and counting without a start write
    start_auto_strap <= 1'b1;
    protect_strap <= 1'b1;
    do_reset(2);
    rd(`WDT_CTRL_OFFSET, got);
    chk8(got, 8'h05);
    repeat (2) begin
      repeat (4) @(posedge clock);
      lsosc_pin <= 1'b1;
      repeat (4) @(posedge clock);
      lsosc_pin <= 1'b0;
    end
    repeat (6) @(posedge clock);
    chk_cnt(14'h3ffd);
    end_sim();
  end
endmodule
`default_nettype wire
